// ==== logic/errlog_pkg.sv ====
package errlog_pkg;
    localparam int NUM_SRC = 20;
    localparam int NUM_QUAD_SRC = 16;
    localparam int SRC_IDX_MNT = 16;
    localparam int SRC_IDX_CFG = 17;
    localparam int SRC_IDX_JTAG = 18;
    localparam int SRC_IDX_I2C = 19;
    localparam int ENTRY_W = 14;
    localparam int CODE_W = 8;
    localparam int SRCC_W = 6;
    localparam int LOG_CODE_LSB = 0;
    localparam int LOG_SRC_LSB = 8;
    // quad sources in port order: 0..3, 4 lanes 0..3, 5..8, 9 lanes 0..3
    localparam logic [5:0] QUAD_SRC_CODE [0:15] = '{
        6'h2A, 6'h29, 6'h34, 6'h33, 6'h32, 6'h31, 6'h3C, 6'h3B,
        6'h3A, 6'h39, 6'h3D, 6'h3E, 6'h1C, 6'h1D, 6'h27, 6'h26};
    localparam logic [5:0] SRC_CODE_MNT = 6'h1E;
    localparam logic [5:0] SRC_CODE_SHARED = 6'h00;
    localparam logic [7:0] ERR_I2C_LENGTH = 8'h10;
    localparam logic [7:0] ERR_I2C_ACK = 8'h11;
    localparam logic [7:0] ERR_I2C_MADDR_INCOMPLETE = 8'h12;
    localparam logic [7:0] ERR_I2C_START_STOP = 8'h13;
    localparam logic [7:0] ERR_I2C_CHECKSUM = 8'h14;
    localparam logic [7:0] ERR_JTAG_INCOMPLETE = 8'h20;
    localparam logic [7:0] ERR_MNT_ROUTE = 8'h30;
    localparam logic [7:0] ERR_MNT_RD_SIZE = 8'h31;
    localparam logic [7:0] ERR_MNT_WR_SIZE = 8'h32;
    localparam logic [7:0] ERR_MNT_TTYPE = 8'h33;
    localparam logic [7:0] ERR_MNT_RD_PAYLOAD = 8'h34;
    localparam logic [7:0] ERR_MNT_WR_NO_PAYLOAD = 8'h35;
    localparam logic [7:0] ERR_MNT_OVERSIZE = 8'h36;
    localparam logic [7:0] MNT_MAX_PAYLOAD = 8'h40;
    localparam logic [7:0] MNT_SIZE_8 = 8'h08;
    localparam logic [7:0] MNT_SIZE_16 = 8'h10;
    localparam logic [7:0] MNT_SIZE_32 = 8'h20;
    localparam logic [7:0] MNT_SIZE_64 = 8'h40;
    localparam logic [1:0] MNT_TYPE_READ = 2'h0;
    localparam logic [1:0] MNT_TYPE_WRITE = 2'h1;
    localparam logic [1:0] I2C_PH_IDLE = 2'h0;
    localparam logic [1:0] I2C_PH_DEVADDR = 2'h1;
    localparam logic [1:0] I2C_PH_MEMADDR = 2'h2;
    localparam logic [1:0] I2C_PH_DATA = 2'h3;
    localparam int FIFO_AW = 4;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [11:0] ADDR_LOG_READ = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_REPORT_EN = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_LOST_CLR_BIT = 1;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_EMPTY_BIT = 8;
    localparam int STAT_FULL_BIT = 9;
    localparam int STAT_LOST_BIT = 10;
    localparam logic [19:0] REPORT_EN_RST = 20'h0_0000;
endpackage : errlog_pkg

// ==== logic/error_log_manager.sv ====
// Summary of operation
// - every arriving error event is logged unless the log is full or cleared at its grant or its source slot is pending, whether or not reporting is enabled
// - one software reporting enable bit per error source
// - each log entry is a 6-bit source and an 8-bit code
// - one shared log; round-robin arbitration grants one source per cycle
// - log read register is 32 bits, source and code in low 14 bits
// - reading the log read register returns the oldest entry
// - software can clear the log fifo and the log read register
// - fixed source codes; quad 0 is 0x2A, maintenance 0x1E, config, jtag and i2c 0x00
// - i2c invalid payload length logs code 0x10
// - missing i2c acknowledge logs 0x11; as master the transfer is terminated
// - external master nack ending our transmit is not logged
// - start/stop during memory address logs 0x12, address kept, write aborted
// - unexpected start/stop as slave logs 0x13, aborting addressing phases
// - start/stop in data phase updates address counter, aborts memory access
// - configuration image checksum mismatch logs 0x14
// - jtag register write ending off a 32-bit boundary logs 0x20
// - maintenance destination neither port nor multicast mask reports 0x30
// - maintenance read of invalid size reports 0x31 with error response
// - maintenance write of invalid size reports 0x32 with error response
// - hop count zero with unexpected transaction field reports 0x33
// - maintenance read carrying payload reports 0x34 with error response
// - write without payload 0x35 with error response; oversize payload 0x36
`timescale 1ns/1ps
module error_log_manager (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] QUAD_ERR_VLD,
    input wire logic [127:0] QUAD_ERR_CODE,
    input wire logic CFG_ERR_VLD,
    input wire logic [7:0] CFG_ERR_CODE,
    input wire logic I2C_LEN_ERR,
    input wire logic I2C_ACK_MISS,
    input wire logic I2C_MASTER,
    input wire logic I2C_SLV_TX_NACK,
    input wire logic I2C_START_STOP,
    input wire logic [1:0] I2C_SLV_PHASE,
    input wire logic I2C_CSUM_DONE,
    input wire logic [15:0] I2C_CSUM_CALC,
    input wire logic [15:0] I2C_CSUM_STORED,
    input wire logic JTAG_WR_END,
    input wire logic [4:0] JTAG_BIT_CNT,
    input wire logic MNT_PKT_VLD,
    input wire logic MNT_DEST_OK,
    input wire logic [1:0] MNT_TYPE,
    input wire logic [7:0] MNT_SIZE,
    input wire logic [7:0] MNT_PAYLOAD_BYTES,
    input wire logic MNT_HOP_ZERO,
    input wire logic MNT_TTYPE_OK,
    output logic I2C_MST_TERMINATE,
    output logic I2C_SLV_ABORT,
    output logic I2C_ADDR_UPDATE,
    output logic MNT_ERR_RESP,
    output logic [19:0] REPORT_EN,
    output logic ERR_REPORT,
    output logic [13:0] ERR_REPORT_ENTRY
);
    localparam int NS = errlog_pkg::NUM_SRC;

    function automatic logic [5:0] rr_pick(input logic [NS-1:0] req, input logic [4:0] last);
        logic [5:0] res;
        int j;
        res = '0;
        // descending so the nearest source after the last grant wins
        for (int k = NS; k >= 1; k--) begin
            j = (int'(last) + k) % NS;
            if (req[j]) begin
                res = {1'b1, 5'(j)};
            end
        end
        return res;
    endfunction : rr_pick

    function automatic logic [5:0] src_code(input logic [4:0] idx);
        logic [5:0] c;
        c = errlog_pkg::SRC_CODE_SHARED;
        if (int'(idx) < errlog_pkg::NUM_QUAD_SRC) begin
            c = errlog_pkg::QUAD_SRC_CODE[idx[3:0]];
        end else if (int'(idx) == errlog_pkg::SRC_IDX_MNT) begin
            c = errlog_pkg::SRC_CODE_MNT;
        end
        return c;
    endfunction : src_code

    function automatic logic size_ok(input logic [7:0] s);
        return (s == errlog_pkg::MNT_SIZE_8) || (s == errlog_pkg::MNT_SIZE_16) ||
               (s == errlog_pkg::MNT_SIZE_32) || (s == errlog_pkg::MNT_SIZE_64);
    endfunction : size_ok

    // event encoding
    wire i2c_ack_err = I2C_ACK_MISS && !I2C_SLV_TX_NACK;
    wire i2c_ss_err = I2C_START_STOP && (I2C_SLV_PHASE != errlog_pkg::I2C_PH_IDLE);
    wire i2c_csum_err = I2C_CSUM_DONE && (I2C_CSUM_CALC != I2C_CSUM_STORED);
    wire [7:0] i2c_ss_code = (I2C_SLV_PHASE == errlog_pkg::I2C_PH_MEMADDR) ?
        errlog_pkg::ERR_I2C_MADDR_INCOMPLETE : errlog_pkg::ERR_I2C_START_STOP;
    wire i2c_any = I2C_LEN_ERR || i2c_ack_err || i2c_ss_err || i2c_csum_err;
    wire [7:0] i2c_code = I2C_LEN_ERR ? errlog_pkg::ERR_I2C_LENGTH :
                          i2c_ack_err ? errlog_pkg::ERR_I2C_ACK :
                          i2c_ss_err ? i2c_ss_code :
                          errlog_pkg::ERR_I2C_CHECKSUM;
    wire jtag_err = JTAG_WR_END && (JTAG_BIT_CNT != 5'h00);

    wire mnt_rd = MNT_TYPE == errlog_pkg::MNT_TYPE_READ;
    wire mnt_wr = MNT_TYPE == errlog_pkg::MNT_TYPE_WRITE;
    wire mnt_has_pl = MNT_PAYLOAD_BYTES != 8'h00;
    wire m_route = !MNT_DEST_OK;
    wire m_ttype = MNT_HOP_ZERO && !MNT_TTYPE_OK;
    wire m_over = MNT_PAYLOAD_BYTES > errlog_pkg::MNT_MAX_PAYLOAD;
    wire m_rd_pl = mnt_rd && mnt_has_pl;
    wire m_wr_nopl = mnt_wr && !mnt_has_pl;
    wire m_rd_sz = mnt_rd && !size_ok(MNT_SIZE);
    wire m_wr_sz = mnt_wr && !size_ok(MNT_SIZE);
    wire mnt_err = MNT_PKT_VLD &&
        (m_route || m_ttype || m_over || m_rd_pl || m_wr_nopl || m_rd_sz || m_wr_sz);
    wire [7:0] mnt_code = m_route ? errlog_pkg::ERR_MNT_ROUTE :
                          m_ttype ? errlog_pkg::ERR_MNT_TTYPE :
                          m_over ? errlog_pkg::ERR_MNT_OVERSIZE :
                          m_rd_pl ? errlog_pkg::ERR_MNT_RD_PAYLOAD :
                          m_wr_nopl ? errlog_pkg::ERR_MNT_WR_NO_PAYLOAD :
                          m_rd_sz ? errlog_pkg::ERR_MNT_RD_SIZE :
                          errlog_pkg::ERR_MNT_WR_SIZE;
    wire mnt_resp = MNT_PKT_VLD && !m_route && !m_ttype && !m_over &&
        (m_rd_pl || m_wr_nopl || m_rd_sz || m_wr_sz);

    logic [NS-1:0] ev_vld;
    logic [NS-1:0][7:0] ev_code;
    always_comb begin
        ev_vld = '0;
        ev_code = '0;
        for (int q = 0; q < errlog_pkg::NUM_QUAD_SRC; q++) begin
            ev_vld[q] = QUAD_ERR_VLD[q];
            ev_code[q] = QUAD_ERR_CODE[q*8 +: 8];
        end
        ev_vld[errlog_pkg::SRC_IDX_MNT] = mnt_err;
        ev_code[errlog_pkg::SRC_IDX_MNT] = mnt_code;
        ev_vld[errlog_pkg::SRC_IDX_CFG] = CFG_ERR_VLD;
        ev_code[errlog_pkg::SRC_IDX_CFG] = CFG_ERR_CODE;
        ev_vld[errlog_pkg::SRC_IDX_JTAG] = jtag_err;
        ev_code[errlog_pkg::SRC_IDX_JTAG] = errlog_pkg::ERR_JTAG_INCOMPLETE;
        ev_vld[errlog_pkg::SRC_IDX_I2C] = i2c_any;
        ev_code[errlog_pkg::SRC_IDX_I2C] = i2c_code;
    end

    // per-source pending slot and arbitration
    logic [NS-1:0] pend_ff;
    logic [NS-1:0] nxt_pend;
    logic [NS-1:0][7:0] pcode_ff;
    logic [NS-1:0][7:0] nxt_pcode;
    logic [4:0] last_ff;
    logic [NS-1:0] collide;

    wire [5:0] pick = rr_pick(pend_ff, last_ff);
    wire gnt_vld = pick[5];
    wire [4:0] gnt_idx = pick[4:0];
    wire [13:0] gnt_entry = {src_code(gnt_idx), pcode_ff[gnt_idx]};

    always_comb begin
        nxt_pend = pend_ff;
        nxt_pcode = pcode_ff;
        collide = '0;
        for (int i = 0; i < NS; i++) begin
            if (gnt_vld && gnt_idx == 5'(i)) begin
                nxt_pend[i] = 1'b0;
            end
            // a new event beats the grant-clear of its own slot
            if (ev_vld[i] && !nxt_pend[i]) begin
                nxt_pend[i] = 1'b1;
                nxt_pcode[i] = ev_code[i];
            end else if (ev_vld[i]) begin
                collide[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pend_ff <= '0;
            pcode_ff <= '0;
            last_ff <= 5'h00;
        end else begin
            pend_ff <= nxt_pend;
            pcode_ff <= nxt_pcode;
            last_ff <= gnt_vld ? gnt_idx : last_ff;
        end
    end

    // apb slave
    logic done_ff;
    logic [31:0] prdata_ff;
    logic [19:0] report_en_ff;
    logic lost_ff;
    logic [4:0] cnt_ff;
    logic [3:0] wptr_ff;
    logic [3:0] rptr_ff;
    logic [13:0] mem_ff [0:15];

    wire access_first = PSEL && PENABLE && !done_ff;
    wire xfer_end = PSEL && PENABLE && done_ff;
    wire sel_log = PADDR == errlog_pkg::ADDR_LOG_READ;
    wire sel_ctrl = PADDR == errlog_pkg::ADDR_CTRL;
    wire sel_en = PADDR == errlog_pkg::ADDR_REPORT_EN;
    wire sel_stat = PADDR == errlog_pkg::ADDR_STATUS;
    wire addr_hit = sel_log || sel_ctrl || sel_en || sel_stat;
    wire wr_end = xfer_end && PWRITE;
    wire clear_w = wr_end && sel_ctrl && PWDATA[errlog_pkg::CTRL_CLEAR_BIT];
    wire lost_clr = wr_end && sel_ctrl && PWDATA[errlog_pkg::CTRL_LOST_CLR_BIT];
    wire empty = cnt_ff == 5'h00;
    wire full = cnt_ff == errlog_pkg::FIFO_DEPTH;
    wire pop_w = xfer_end && !PWRITE && sel_log && !empty && !clear_w;
    wire push_w = gnt_vld && (!full || pop_w) && !clear_w;
    wire drop_w = (gnt_vld && !push_w) || (collide != '0);
    wire [31:0] head_word = empty ? 32'h0000_0000 :
        {18'h0_0000, mem_ff[rptr_ff]};
    wire [31:0] stat_word = {21'h00_0000, lost_ff, full, empty, 3'h0, cnt_ff};
    wire [31:0] rd_mux = sel_log ? head_word :
                         sel_en ? {12'h000, report_en_ff} :
                         sel_stat ? stat_word : 32'h0000_0000;

    assign PREADY = done_ff;
    assign PSLVERR = done_ff && !addr_hit;
    assign PRDATA = prdata_ff;
    assign REPORT_EN = report_en_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            done_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            report_en_ff <= errlog_pkg::REPORT_EN_RST;
            lost_ff <= 1'b0;
        end else begin
            done_ff <= access_first;
            if (access_first && !PWRITE) begin
                prdata_ff <= rd_mux;
            end else if (clear_w) begin
                prdata_ff <= 32'h0000_0000;
            end
            if (wr_end && sel_en) begin
                report_en_ff <= PWDATA[19:0];
            end
            lost_ff <= drop_w || (lost_ff && !lost_clr);
        end
    end

    // log fifo
    always_ff @(posedge CLK_SYS) begin
        if (SRST || clear_w) begin
            cnt_ff <= 5'h00;
            wptr_ff <= 4'h0;
            rptr_ff <= 4'h0;
        end else begin
            cnt_ff <= 5'(cnt_ff + {4'h0, push_w} - {4'h0, pop_w});
            wptr_ff <= push_w ? 4'(wptr_ff + 4'h1) : wptr_ff;
            rptr_ff <= pop_w ? 4'(rptr_ff + 4'h1) : rptr_ff;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (push_w) begin
            mem_ff[wptr_ff] <= gnt_entry;
        end
    end

    // side effects to sources
    logic term_ff;
    logic abort_ff;
    logic addr_upd_ff;
    logic mresp_ff;
    logic report_ff;
    logic [13:0] rentry_ff;

    assign I2C_MST_TERMINATE = term_ff;
    assign I2C_SLV_ABORT = abort_ff;
    assign I2C_ADDR_UPDATE = addr_upd_ff;
    assign MNT_ERR_RESP = mresp_ff;
    assign ERR_REPORT = report_ff;
    assign ERR_REPORT_ENTRY = rentry_ff;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            term_ff <= 1'b0;
            abort_ff <= 1'b0;
            addr_upd_ff <= 1'b0;
            mresp_ff <= 1'b0;
            report_ff <= 1'b0;
            rentry_ff <= 14'h0000;
        end else begin
            term_ff <= i2c_ack_err && I2C_MASTER;
            abort_ff <= i2c_ss_err;
            addr_upd_ff <= i2c_ss_err && (I2C_SLV_PHASE == errlog_pkg::I2C_PH_DATA);
            mresp_ff <= mnt_resp;
            report_ff <= push_w && report_en_ff[gnt_idx];
            rentry_ff <= push_w ? gnt_entry : rentry_ff;
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    property p_push_entry;
        logic [3:0] w;
        logic [13:0] e;
        (push_w, w = wptr_ff, e = gnt_entry) |=> mem_ff[w] == e;
    endproperty
    a_push_entry: assert property (p_push_entry)
        else $error("granted entry not written to log");

    property p_grant_busy;
        (pend_ff != '0) |-> gnt_vld && pend_ff[gnt_idx];
    endproperty
    a_grant_busy: assert property (p_grant_busy)
        else $error("pending source not granted");

    property p_mnt_src;
        gnt_vld && gnt_idx == 5'(errlog_pkg::SRC_IDX_MNT) |->
            gnt_entry[13:8] == errlog_pkg::SRC_CODE_MNT;
    endproperty
    a_mnt_src: assert property (p_mnt_src)
        else $error("wrong maintenance source code");

    property p_report_gate;
        ERR_REPORT |-> $past(report_en_ff[gnt_idx]) && $past(push_w);
    endproperty
    a_report_gate: assert property (p_report_gate)
        else $error("report for disabled source");

    property p_empty_read;
        access_first && !PWRITE && sel_log && empty && !push_w |=> PREADY && PRDATA == '0;
    endproperty
    a_empty_read: assert property (p_empty_read)
        else $error("empty log read not zero");

    property p_pop_count;
        pop_w && !push_w |=> cnt_ff == 5'($past(cnt_ff) - 5'h01);
    endproperty
    a_pop_count: assert property (p_pop_count)
        else $error("read did not remove entry");

    property p_clear;
        clear_w |=> empty && PRDATA == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear left log or read register");

    property p_full_drop;
        full && !pop_w && !clear_w |=> full && $stable(wptr_ff) && $stable(rptr_ff);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("full log changed");

    property p_master_ack;
        I2C_ACK_MISS && I2C_MASTER && !I2C_SLV_TX_NACK |=> I2C_MST_TERMINATE;
    endproperty
    a_master_ack: assert property (p_master_ack)
        else $error("master transfer not terminated");

    property p_nack_quiet;
        I2C_ACK_MISS && I2C_SLV_TX_NACK && !I2C_LEN_ERR && !i2c_ss_err && !i2c_csum_err
            |-> !ev_vld[errlog_pkg::SRC_IDX_I2C];
    endproperty
    a_nack_quiet: assert property (p_nack_quiet)
        else $error("read-ending nack logged");

    property p_rd_size;
        MNT_PKT_VLD && MNT_DEST_OK && !m_ttype && !m_over && m_rd_sz ##1 1'b1
            |-> MNT_ERR_RESP;
    endproperty
    a_rd_size: assert property (p_rd_size)
        else $error("no error response on bad read size");

    property p_jtag;
        JTAG_WR_END && JTAG_BIT_CNT != 5'h00 && !pend_ff[errlog_pkg::SRC_IDX_JTAG] |=>
            pend_ff[errlog_pkg::SRC_IDX_JTAG] &&
            pcode_ff[errlog_pkg::SRC_IDX_JTAG] == errlog_pkg::ERR_JTAG_INCOMPLETE;
    endproperty
    a_jtag: assert property (p_jtag)
        else $error("jtag incomplete write code wrong");

    property p_ready;
        access_first |=> PREADY ##1 !PREADY;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer not one cycle after access");

    c_full: cover property (full && gnt_vld);
    c_clear: cover property (clear_w && !empty);
    c_empty_read: cover property (access_first && sel_log && empty);
    c_two_src: cover property ($countones(pend_ff) > 1);
endmodule : error_log_manager

// ==== tb/err_src_model.sv ====
`timescale 1ns/1ps
module err_src_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [4:0] sel,
    output logic [15:0] quad_vld,
    output logic [127:0] quad_code,
    output logic cfg_vld,
    output logic [7:0] cfg_code,
    output logic i2c_len,
    output logic i2c_ack,
    output logic i2c_master,
    output logic i2c_nack,
    output logic i2c_ss,
    output logic [1:0] i2c_phase,
    output logic csum_done,
    output logic [15:0] csum_calc,
    output logic [15:0] csum_stored,
    output logic jtag_end,
    output logic [4:0] jtag_cnt,
    output logic mnt_vld,
    output logic mnt_dest_ok,
    output logic [1:0] mnt_type,
    output logic [7:0] mnt_size,
    output logic [7:0] mnt_payload,
    output logic mnt_hop0,
    output logic mnt_ttype_ok
);
    // sel picks one error scenario; fire_ff makes it a one-cycle event
    logic fire_ff = 1'b0;
    logic [4:0] sel_ff = 5'h1F;
    logic [7:0] junk_ff = 8'hA5;
    always @(posedge clk) begin
        fire_ff <= go;
        sel_ff <= go ? sel : sel_ff;
        junk_ff <= junk_ff + 8'h3B;
    end
    // codes outside an event carry a changing pattern, not the last value
    always_comb begin
        for (int q = 0; q < 16; q++) begin
            quad_code[8*q +: 8] = !fire_ff ? junk_ff : (sel_ff == 5'd17) ? 8'h60 : 8'(q);
        end
    end
    assign quad_vld = !fire_ff ? 16'h0000 : (sel_ff == 5'd16) ? 16'hFFFF : {15'h0, sel_ff == 5'd17};
    assign cfg_vld = fire_ff && (sel_ff == 5'd15 || sel_ff == 5'd16);
    assign cfg_code = !fire_ff ? junk_ff : (sel_ff == 5'd15) ? 8'h50 : 8'h55;
    assign i2c_len = fire_ff && sel_ff == 5'd0;
    assign i2c_ack = fire_ff && (sel_ff == 5'd1 || sel_ff == 5'd2);
    assign i2c_master = sel_ff == 5'd1;
    assign i2c_nack = sel_ff == 5'd2;
    assign i2c_ss = fire_ff && sel_ff >= 5'd3 && sel_ff <= 5'd5;
    assign i2c_phase = (sel_ff == 5'd3) ? 2'h2 : (sel_ff == 5'd4) ? 2'h1 : 2'h3;
    assign csum_done = fire_ff && sel_ff == 5'd6;
    assign csum_calc = 16'h1234;
    assign csum_stored = (sel_ff == 5'd6) ? 16'h1235 : 16'h1234;
    assign jtag_end = fire_ff && sel_ff == 5'd7;
    assign jtag_cnt = 5'h05;
    assign mnt_vld = fire_ff && sel_ff >= 5'd8 && sel_ff <= 5'd14;
    assign mnt_dest_ok = sel_ff != 5'd8;
    assign mnt_type = (sel_ff == 5'd10 || sel_ff >= 5'd13) ? 2'h1 : 2'h0;
    assign mnt_size = (sel_ff == 5'd9 || sel_ff == 5'd10) ? 8'h0C : 8'h08;
    assign mnt_payload = (sel_ff == 5'd10) ? 8'h0C : (sel_ff == 5'd12) ? 8'h08 :
                         (sel_ff == 5'd14) ? 8'h50 : 8'h00;
    assign mnt_hop0 = sel_ff == 5'd11;
    assign mnt_ttype_ok = sel_ff != 5'd11;
endmodule : err_src_model

// ==== tb/error_log_manager_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module error_log_manager_tb;
    logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic [4:0] sel = 5'h00;
    logic pready, pslverr, errv, term, abort, upd, resp, err_report;
    logic [15:0] quad_vld, csum_calc, csum_stored;
    logic [127:0] quad_code;
    logic cfg_vld, i2c_len, i2c_ack, i2c_master, i2c_nack, i2c_ss, csum_done, jtag_end;
    logic mnt_vld, mnt_dest_ok, mnt_hop0, mnt_ttype_ok;
    logic [7:0] cfg_code, mnt_size, mnt_payload;
    logic [1:0] i2c_phase, mnt_type;
    logic [4:0] jtag_cnt;
    logic [19:0] report_en;
    logic [13:0] rep_entry;
    logic [31:0] expv;
    int bad_count = 0, checks = 0, rep_count = 0;
    logic [13:0] exp_entry [0:15] = '{14'h0010, 14'h0011, 14'h0000, 14'h0012, 14'h0013,
        14'h0013, 14'h0014, 14'h0020, 14'h1E30, 14'h1E31, 14'h1E32, 14'h1E33, 14'h1E34,
        14'h1E35, 14'h1E36, 14'h0050};
    logic [3:0] exp_flags [0:15] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h4, 4'h6, 4'h0, 4'h0,
        4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0};
    error_log_manager error_log_manager_i (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .QUAD_ERR_VLD(quad_vld), .QUAD_ERR_CODE(quad_code),
        .CFG_ERR_VLD(cfg_vld), .CFG_ERR_CODE(cfg_code), .I2C_LEN_ERR(i2c_len),
        .I2C_ACK_MISS(i2c_ack), .I2C_MASTER(i2c_master), .I2C_SLV_TX_NACK(i2c_nack),
        .I2C_START_STOP(i2c_ss), .I2C_SLV_PHASE(i2c_phase), .I2C_CSUM_DONE(csum_done),
        .I2C_CSUM_CALC(csum_calc), .I2C_CSUM_STORED(csum_stored), .JTAG_WR_END(jtag_end),
        .JTAG_BIT_CNT(jtag_cnt), .MNT_PKT_VLD(mnt_vld), .MNT_DEST_OK(mnt_dest_ok),
        .MNT_TYPE(mnt_type), .MNT_SIZE(mnt_size), .MNT_PAYLOAD_BYTES(mnt_payload),
        .MNT_HOP_ZERO(mnt_hop0), .MNT_TTYPE_OK(mnt_ttype_ok), .I2C_MST_TERMINATE(term),
        .I2C_SLV_ABORT(abort), .I2C_ADDR_UPDATE(upd), .MNT_ERR_RESP(resp),
        .REPORT_EN(report_en), .ERR_REPORT(err_report), .ERR_REPORT_ENTRY(rep_entry));
    err_src_model err_src_model_i (.clk(clk_sys), .go(go), .sel(sel), .quad_vld(quad_vld),
        .quad_code(quad_code), .cfg_vld(cfg_vld), .cfg_code(cfg_code), .i2c_len(i2c_len),
        .i2c_ack(i2c_ack), .i2c_master(i2c_master), .i2c_nack(i2c_nack), .i2c_ss(i2c_ss),
        .i2c_phase(i2c_phase), .csum_done(csum_done), .csum_calc(csum_calc),
        .csum_stored(csum_stored), .jtag_end(jtag_end), .jtag_cnt(jtag_cnt),
        .mnt_vld(mnt_vld), .mnt_dest_ok(mnt_dest_ok), .mnt_type(mnt_type),
        .mnt_size(mnt_size), .mnt_payload(mnt_payload), .mnt_hop0(mnt_hop0),
        .mnt_ttype_ok(mnt_ttype_ok));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (err_report === 1'b1) begin
            rep_count <= rep_count + 1;
        end
    end
    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        errv = pslverr;
        if (n >= 50) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one event from the model; the response pulses stand in the second cycle after
    task automatic fire(input logic [4:0] s);
        @(posedge clk_sys);
        go <= 1'b1;
        sel <= s;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        if (s < 5'd16) `CHK({term, abort, upd, resp}, exp_flags[s])
        repeat (4) @(posedge clk_sys);
    endtask : fire
    initial begin
        #500_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rdv, 32'h0000_0100)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdv, 32'h0000_0000)
        apb(1'b1, 12'h008, 32'h0008_0001);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rdv, 32'h0008_0001)
        `CHK(report_en, 20'h8_0001)
        for (int s = 0; s < 16; s++) begin
            fire(5'(s));
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rdv, {18'h0, exp_entry[s]})
        end
        fire(5'd17);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdv, 32'h0000_2A60)
        `CHK(rep_entry, 14'h2A60)
        `CHK(rep_count, 7)
        fire(5'd16);
        repeat (25) @(posedge clk_sys);
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rdv, 32'h0000_0610)
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, 12'h000, 32'h0);
            expv = (i < 15) ? {18'h0_0000, errlog_pkg::QUAD_SRC_CODE[i + 1], 8'(i + 1)} :
                32'h0000_0055;
            `CHK(rdv, expv)
        end
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rdv, 32'h0000_0500)
        fire(5'd17);
        apb(1'b1, 12'h004, 32'h0000_0003);
        @(posedge clk_sys);
        `CHK(prdata, 32'h0000_0000)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rdv, 32'h0000_0100)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({errv, rdv}, {1'b1, 32'h0000_0000})
        report_and_stop();
    end
endmodule : error_log_manager_tb
